// [src/mrf_defines.svh]
// constants for the multidrop response formatter
`ifndef MRF_DEFINES_SVH
`define MRF_DEFINES_SVH

// ----
// timing
// ----
`define MRF_LATENCY_MS 200
`define MRF_CLK_HZ 100000000
`define MRF_CNT_W 25

// ----
// identity and reset values
// ----
`define MRF_GAS_BCD 12'h310
`define MRF_ID_RST 16'h0168
`define MRF_CTRL_RST 7'h06
`define MRF_MAP_USE 16'h0FFF
`define MRF_MAP_RST {16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, \
    16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001}
`define MRF_UNIT_LSB 13

// ----
// register byte addresses
// ----
`define MRF_A_CTRL 8'h00
`define MRF_A_DEV_ID 8'h04
`define MRF_A_GAS_ID 8'h08
`define MRF_A_STATUS 8'h0C
`define MRF_A_IRQ_STAT 8'h10
`define MRF_A_IRQ_MASK 8'h14
`define MRF_A_ENGINE 8'h18
`define MRF_A_MAP0 8'h40
`define MRF_A_MAP_END 8'h70

// ----
// interrupt bits and characters
// ----
`define MRF_IRQ_W 3
`define MRF_IRQ_DONE 0
`define MRF_IRQ_DROP 1
`define MRF_IRQ_ACC 2
`define MRF_CH_STX 7'h02
`define MRF_CH_ETX 7'h03
`define MRF_CH_CR 7'h0D
`define MRF_CH_SP 7'h20
`define MRF_CH_ZERO 7'h30
`define MRF_CH_ALPHA 7'h37
`define MRF_BODY_LAST 3'h7
`define MRF_GAS_CHARS 3'h3

`endif

// [src/mrf_pkg.sv]
// types shared by the multidrop response formatter
package mrf_pkg;
    // ----
    // modes, framings and units
    // ----
    typedef enum logic [1:0] {RM_CMD, RM_BLOCK, RM_TEXT, RM_RSVD} mrf_resp_mode_t;
    typedef enum logic [1:0] {FR_PLAIN, FR_BLOCK, FR_TEXT, FR_RSVD} mrf_frame_t;
    typedef enum logic [1:0] {
        UNIT_MICROGRAMS_PER_M3, UNIT_MILLIGRAMS_PER_M3, UNIT_PARTS_PER_BILLION, UNIT_PARTS_PER_MILLION
    } mrf_unit_t;

    // ----
    // carriers
    // ----
    typedef struct packed {
        mrf_unit_t unit;
        mrf_resp_mode_t mode;
        logic serial_port_b_en;
        logic serial_port_a_en;
        logic proto_v2;
    } mrf_ctrl_t;

    typedef struct packed {
        logic [15:0] id;
        logic port_b;
        mrf_frame_t enc;
    } mrf_cmd_t;

    typedef struct packed {
        logic [6:0] char;
        logic parity;
        logic port_b;
    } mrf_tx_t;
endpackage

// [src/mrf_hex_ascii.sv]
// one nibble to one ascii hex digit
`timescale 1ns/1ps
`default_nettype none
`include "mrf_defines.svh"
module mrf_hex_ascii (
    input wire logic [3:0] nib_in,
    output logic [6:0] char_out
);
    // digits and upper-case letters
    assign char_out = ((nib_in < 4'hA) ? `MRF_CH_ZERO : `MRF_CH_ALPHA) + {3'h0, nib_in};
endmodule
`default_nettype wire

// [src/mrf_status_builder.sv]
// status word assembly from a flag snapshot and a bit mapping
`timescale 1ns/1ps
`default_nettype none
`include "mrf_defines.svh"
module mrf_status_builder
    import mrf_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic snap_in,
    input wire logic [11:0] flags_in,
    input wire logic [11:0][15:0] maps_in,
    input wire mrf_unit_t unit_in,
    output logic [15:0] status_out
);
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [15:0] acc;

    // ----
    // mapping
    // ----
    // any active flag lights every bit it maps to; unit bits and spares are kept out
    always_comb begin
        acc = 16'h0000;
        for (int i = 0; i < 12; i++) begin
            if (flags_in[i]) begin
                acc = acc | (maps_in[i] & `MRF_MAP_USE); // see (R14)
            end
        end
        acc[`MRF_UNIT_LSB +: 2] = unit_in; // see (R13)
        status_nxt = snap_in ? acc : status_r; // see (R19)
    end

    // one snapshot per reply, so a reply never mixes two moments
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_r <= 16'h0000;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status_out = status_r; // see (R10)
endmodule
`default_nettype wire

// [src/mrf_formatter.sv]
// multidrop response formatter: register slave, latency timer and reply framer
//
// Behaviour
// (R1) a reply starts 200 ms after its command
// (R2) the host paces commands to the reply latency
// (R3) one control bit picks protocol version 1 or version 2
// (R4) each of the two serial ports has its own multidrop enable
// (R5) the version choice is shared by both serial ports
// (R6) command-following mode frames each reply like its triggering command
// (R7) block mode sends start, body, end and a two-digit block check
// (R8) text mode puts a carriage return before and after every reply
// (R9) the gas code 310 is part of every reply
// (R10) every reply carries the sixteen-bit status word
// (R11) warning flags default to bits 0001 through 0080
// (R12) operational flags default to bits 0100 through 0800
// (R13) bits 13 and 14 carry the unit; 1000 and 8000 stay spare
// (R14) a bit shared by several flags is set if any is active
// (R15) the device has its own id, 360 after reset, used for addressing
// (R16) the device never speaks unasked and answers only its own id
// (R17) link characters are seven bits with even parity, half duplex
// (R18) the block check is the xor of all reply characters, in hex
// (R19) flags are sampled once per reply as one coherent snapshot
`timescale 1ns/1ps
`default_nettype none
`include "mrf_defines.svh"
module mrf_formatter
    import mrf_pkg::*;
#(
    parameter int unsigned P_LATENCY_CYCLES = `MRF_LATENCY_MS * (`MRF_CLK_HZ / 1000)
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic cmd_valid_in,
    input wire mrf_cmd_t cmd_in,
    input wire logic [11:0] flags_in,
    input wire logic tx_ready_in,
    output logic tx_valid_out,
    output mrf_tx_t tx_out,
    output logic busy_out,
    output logic proto_v2_out,
    output logic irq_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT, ST_LEAD, ST_BODY, ST_TRAIL, ST_CHK_HI, ST_CHK_LO
    } mrf_state_t;

    // ----
    // register state
    // ----
    mrf_ctrl_t ctrl_r, ctrl_nxt;
    logic [15:0] dev_id_r, dev_id_nxt;
    logic [11:0][15:0] map_r, map_nxt;
    logic [`MRF_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [`MRF_IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic irq_r, irq_nxt;
    logic ack_r, ack_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic v2_r, v2_nxt;

    // ----
    // engine state
    // ----
    mrf_state_t st_r, st_nxt;
    logic [`MRF_CNT_W-1:0] cnt_r, cnt_nxt;
    mrf_frame_t frame_r, frame_nxt;
    logic port_b_r, port_b_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [6:0] chk_r, chk_nxt;
    logic tx_valid_r, tx_valid_nxt;
    mrf_tx_t tx_r, tx_nxt;
    logic busy_r, busy_nxt;

    logic snap;
    logic ev_done;
    logic ev_drop;
    logic ev_acc;
    logic id_match;
    logic port_on;
    logic [15:0] status_word;
    logic [35:0] nibs;
    logic [8:0][6:0] hex_ch;
    logic [6:0] body_ch;
    logic [6:0] cur_ch;
    logic [7:0] map_off;
    logic [3:0] map_idx;
    logic map_hit;

    // ----
    // status word and hex digits
    // ----
    mrf_status_builder u_status (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .snap_in(snap),
        .flags_in(flags_in),
        .maps_in(map_r),
        .unit_in(ctrl_r.unit),
        .status_out(status_word)
    );

    // gas code, status word and block check, most significant nibble first
    assign nibs = {`MRF_GAS_BCD, status_word, 1'b0, chk_r}; // see (R9) see (R10)

    for (genvar k = 0; k < 9; k++) begin : g_hex
        mrf_hex_ascii u_hex (
            .nib_in(nibs[35 - 4 * k -: 4]),
            .char_out(hex_ch[k])
        );
    end

    // ----
    // character selection
    // ----
    // body: three gas digits, a space, four status digits
    always_comb begin
        if (idx_r < `MRF_GAS_CHARS) begin
            body_ch = hex_ch[idx_r];
        end else if (idx_r == `MRF_GAS_CHARS) begin
            body_ch = `MRF_CH_SP;
        end else begin
            body_ch = hex_ch[idx_r - 3'h1];
        end
    end

    // delimiters depend on the framing fixed when the command was taken
    always_comb begin
        unique case (st_r)
            ST_LEAD: cur_ch = (frame_r == FR_BLOCK) ? `MRF_CH_STX : `MRF_CH_CR; // see (R7) see (R8)
            ST_TRAIL: cur_ch = (frame_r == FR_BLOCK) ? `MRF_CH_ETX : `MRF_CH_CR; // see (R7) see (R8)
            ST_CHK_HI: cur_ch = hex_ch[7]; // see (R18)
            ST_CHK_LO: cur_ch = hex_ch[8]; // see (R18)
            default: cur_ch = body_ch;
        endcase
    end

    // ----
    // command filter
    // ----
    // only commands carrying this id on an enabled port start a reply
    assign id_match = cmd_valid_in && (cmd_in.id == dev_id_r); // see (R15) see (R16)
    assign port_on = cmd_in.port_b ? ctrl_r.serial_port_b_en : ctrl_r.serial_port_a_en; // see (R4)

    // ----
    // reply engine, next state
    // ----
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        frame_nxt = frame_r;
        port_b_nxt = port_b_r;
        idx_nxt = idx_r;
        chk_nxt = chk_r;
        tx_valid_nxt = tx_valid_r;
        tx_nxt = tx_r;
        snap = 1'b0;
        ev_done = 1'b0;
        ev_acc = 1'b0;
        // a command for us while a reply is pending is dropped, not queued
        ev_drop = id_match && (st_r != ST_IDLE); // see (R2)
        unique case (st_r)
            ST_IDLE: begin
                if (id_match && port_on) begin
                    ev_acc = 1'b1;
                    st_nxt = ST_WAIT;
                    cnt_nxt = `MRF_CNT_W'(P_LATENCY_CYCLES - 1); // see (R1)
                    port_b_nxt = cmd_in.port_b;
                    unique case (ctrl_r.mode)
                        RM_BLOCK: frame_nxt = FR_BLOCK; // see (R7)
                        RM_TEXT: frame_nxt = FR_TEXT; // see (R8)
                        default: frame_nxt = (cmd_in.enc == FR_RSVD) ? FR_PLAIN : cmd_in.enc; // see (R6)
                    endcase
                end
            end
            ST_WAIT: begin
                if (cnt_r == '0) begin
                    // flags are frozen here for the whole reply
                    snap = 1'b1; // see (R19)
                    idx_nxt = 3'h0;
                    chk_nxt = 7'h00;
                    st_nxt = (frame_r == FR_PLAIN) ? ST_BODY : ST_LEAD;
                end else begin
                    cnt_nxt = cnt_r - `MRF_CNT_W'(1); // see (R1)
                end
            end
            default: begin
                if (!tx_valid_r) begin
                    tx_valid_nxt = 1'b1;
                    tx_nxt.char = cur_ch;
                    tx_nxt.parity = ^cur_ch; // see (R17)
                    tx_nxt.port_b = port_b_r;
                    if (st_r != ST_CHK_HI && st_r != ST_CHK_LO) begin
                        chk_nxt = chk_r ^ cur_ch; // see (R18)
                    end
                end else if (tx_ready_in) begin
                    tx_valid_nxt = 1'b0;
                    unique case (st_r)
                        ST_LEAD: st_nxt = ST_BODY;
                        ST_BODY: begin
                            if (idx_r != `MRF_BODY_LAST) begin
                                idx_nxt = idx_r + 3'h1;
                            end else if (frame_r == FR_PLAIN) begin
                                st_nxt = ST_IDLE;
                                ev_done = 1'b1;
                            end else begin
                                st_nxt = ST_TRAIL;
                            end
                        end
                        ST_TRAIL: begin
                            if (frame_r == FR_BLOCK) begin
                                st_nxt = ST_CHK_HI; // see (R7)
                            end else begin
                                st_nxt = ST_IDLE;
                                ev_done = 1'b1;
                            end
                        end
                        ST_CHK_HI: st_nxt = ST_CHK_LO;
                        default: begin
                            st_nxt = ST_IDLE;
                            ev_done = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        // half duplex: the port is ours from acceptance to the last character
        busy_nxt = (st_nxt != ST_IDLE); // see (R17)
    end

    // reply engine registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            frame_r <= FR_PLAIN;
            port_b_r <= 1'b0;
            idx_r <= 3'h0;
            chk_r <= 7'h00;
            tx_valid_r <= 1'b0;
            tx_r <= '0;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            frame_r <= frame_nxt;
            port_b_r <= port_b_nxt;
            idx_r <= idx_nxt;
            chk_r <= chk_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_r <= tx_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----
    // register bus, next state
    // ----
    assign map_off = avs_address_in - `MRF_A_MAP0;
    assign map_idx = map_off[5:2];
    assign map_hit = (avs_address_in >= `MRF_A_MAP0) && (avs_address_in < `MRF_A_MAP_END)
        && (avs_address_in[1:0] == 2'h0);

    // one wait cycle per access: data is prepared, then waitrequest drops
    always_comb begin
        ctrl_nxt = ctrl_r;
        dev_id_nxt = dev_id_r;
        map_nxt = map_r;
        irq_mask_nxt = irq_mask_r;
        rdata_nxt = rdata_r;
        irq_stat_nxt = irq_stat_r;
        ack_nxt = (avs_read_in || avs_write_in) && !ack_r;
        wait_nxt = !ack_nxt;
        if (avs_read_in && !ack_r) begin
            rdata_nxt = 32'h0000_0000;
            if (map_hit) begin
                rdata_nxt[15:0] = map_r[map_idx];
            end else begin
                unique case (avs_address_in)
                    `MRF_A_CTRL: rdata_nxt[6:0] = ctrl_r;
                    `MRF_A_DEV_ID: rdata_nxt[15:0] = dev_id_r;
                    `MRF_A_GAS_ID: rdata_nxt[11:0] = `MRF_GAS_BCD; // see (R9)
                    `MRF_A_STATUS: rdata_nxt[15:0] = status_word;
                    `MRF_A_IRQ_STAT: rdata_nxt[`MRF_IRQ_W-1:0] = irq_stat_r;
                    `MRF_A_IRQ_MASK: rdata_nxt[`MRF_IRQ_W-1:0] = irq_mask_r;
                    `MRF_A_ENGINE: rdata_nxt[3:0] = {busy_r, st_r};
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        if (avs_write_in && ack_r) begin
            if (map_hit) begin
                map_nxt[map_idx] = avs_writedata_in[15:0] & `MRF_MAP_USE; // see (R11) see (R12)
            end else begin
                unique case (avs_address_in)
                    // one version bit serves both ports
                    `MRF_A_CTRL: ctrl_nxt = avs_writedata_in[6:0]; // see (R3) see (R5)
                    `MRF_A_DEV_ID: dev_id_nxt = avs_writedata_in[15:0]; // see (R15)
                    `MRF_A_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~avs_writedata_in[`MRF_IRQ_W-1:0];
                    `MRF_A_IRQ_MASK: irq_mask_nxt = avs_writedata_in[`MRF_IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
        // events are applied after the clear so a same-cycle event survives
        if (ev_done) begin
            irq_stat_nxt[`MRF_IRQ_DONE] = 1'b1;
        end
        if (ev_drop) begin
            irq_stat_nxt[`MRF_IRQ_DROP] = 1'b1;
        end
        if (ev_acc) begin
            irq_stat_nxt[`MRF_IRQ_ACC] = 1'b1;
        end
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
        v2_nxt = ctrl_nxt.proto_v2; // see (R3)
    end

    // register bus registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= `MRF_CTRL_RST;
            dev_id_r <= `MRF_ID_RST; // see (R15)
            map_r <= `MRF_MAP_RST; // see (R11) see (R12)
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
            ack_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            v2_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            dev_id_r <= dev_id_nxt;
            map_r <= map_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r <= irq_nxt;
            ack_r <= ack_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            v2_r <= v2_nxt;
        end
    end

    // ----
    // outputs
    // ----
    assign avs_readdata_out = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign tx_valid_out = tx_valid_r; // see (R16)
    assign tx_out = tx_r;
    assign busy_out = busy_r;
    assign proto_v2_out = v2_r;
    assign irq_out = irq_r;
endmodule
`default_nettype wire

// [bench/mrf_formatter_chk.sv]
// port checker for the multidrop response formatter
`timescale 1ns/1ps
`default_nettype none
module mrf_formatter_chk
    import mrf_pkg::*;
#(
    parameter int unsigned P_LATENCY_CYCLES = 20
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic tx_ready_in,
    input wire logic tx_valid_out,
    input wire mrf_tx_t tx_out,
    input wire logic busy_out,
    input wire logic proto_v2_out
);
    // ------
    // helper counters
    // ------
    logic [31:0] wait_r, wait_nxt;
    logic sent_r, sent_nxt;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // busy cycles so far, and whether this reply already showed a character
    always_comb begin
        wait_nxt = busy_out ? wait_r + 32'h1 : 32'h0;
        sent_nxt = busy_out && (sent_r || tx_valid_out);
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_r <= 32'h0;
            sent_r <= 1'h0;
        end else begin
            wait_r <= wait_nxt;
            sent_r <= sent_nxt;
        end
    end
    // ------
    // assertions
    // ------
    lat_wait_a: assert property (
        $rose(tx_valid_out) && !sent_r |-> wait_r >= P_LATENCY_CYCLES && wait_r <= P_LATENCY_CYCLES + 4)
        else $error("first character outside latency window");
    v2_copy_a: assert property (
        avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00
        |-> ##2 proto_v2_out == $past(avs_writedata_in[0], 2))
        else $error("version output does not follow control");
    char_parity_a: assert property (tx_valid_out |-> tx_out.parity == ^tx_out.char)
        else $error("parity not even");
    char_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_out))
        else $error("character changed before taken");
    no_unasked_a: assert property (tx_valid_out |-> busy_out)
        else $error("character outside a reply");
    busy_end_a: assert property ($fell(busy_out) |-> $past(tx_valid_out && tx_ready_in))
        else $error("busy fell without a taken character");
    gas_code_a: assert property (
        avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h08 |-> avs_readdata_out == 32'h310)
        else $error("gas code wrong");
    map_spare_a: assert property (
        avs_read_in && !avs_waitrequest_out && avs_address_in >= 8'h40 && avs_address_in < 8'h70
        |-> avs_readdata_out[31:12] == 20'h0)
        else $error("map reaches spare bits");
    one_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer not after one wait");
    cover property ($rose(busy_out));
    cover property (tx_valid_out && !tx_ready_in);
    cover property (avs_write_in && !avs_waitrequest_out);
endmodule
bind mrf_formatter mrf_formatter_chk #(.P_LATENCY_CYCLES(P_LATENCY_CYCLES)) i_chk (.clk_sys_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .tx_ready_in, .tx_valid_out, .tx_out, .busy_out, .proto_v2_out);
`default_nettype wire

// [bench/mrf_host_model.sv]
// host model: addresses devices and takes reply characters
`timescale 1ns/1ps
`default_nettype none
module mrf_host_model
    import mrf_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic tx_valid_in,
    input wire mrf_tx_t tx_in,
    output var logic tx_ready_out,
    output var logic cmd_valid_out,
    output var mrf_cmd_t cmd_out
);
    logic slow = 1'h0;
    mrf_tx_t rx_q[$];
    initial begin
        tx_ready_out = 1'h0;
        cmd_valid_out = 1'h0;
        cmd_out = '0;
    end
    // prompt link, or one that stalls at random, ready one cycle in four, to stretch characters
    always @(posedge clk_sys_in) begin
        tx_ready_out <= !slow || ($urandom_range(3) == 0);
    end
    // half duplex: each taken character kept whole with parity and port
    always @(posedge clk_sys_in) begin
        if (tx_valid_in && tx_ready_out) rx_q.push_back(tx_in);
    end
    // one-cycle command; the lines are scrambled once released
    task automatic send(input logic [15:0] id, input logic pb, input logic [1:0] enc);
        cmd_out <= {id, pb, enc};
        cmd_valid_out <= 1'h1;
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'h0;
        cmd_out <= ~{id, pb, enc};
    endtask
endmodule
`default_nettype wire

// [bench/mrf_formatter_tb.sv]
// self-checking bench for the multidrop response formatter
`timescale 1ns/1ps
`default_nettype none
module mrf_formatter_tb import mrf_pkg::*;;
    localparam int unsigned LAT = 20;
    logic clk_sys_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'h0;
    logic avs_write_in = 1'h0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out, cmd_valid_in, tx_ready_in, tx_valid_out, busy_out, proto_v2_out, irq_out;
    mrf_cmd_t cmd_in;
    mrf_tx_t tx_out;
    logic [11:0] flags_in = 12'h000;
    int failures = 0;
    int comparisons = 0;
    logic [15:0] map_m [12];
    mrf_tx_t exp_q[$];
    always #5 clk_sys_in = ~clk_sys_in;
    mrf_formatter #(.P_LATENCY_CYCLES(LAT)) i_dut (.clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .cmd_valid_in, .cmd_in,
        .flags_in, .tx_ready_in, .tx_valid_out, .tx_out, .busy_out, .proto_v2_out, .irq_out);
    mrf_host_model i_host (.clk_sys_in, .tx_valid_in(tx_valid_out), .tx_in(tx_out), .tx_ready_out(tx_ready_in),
        .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
    // ------
    // checking and bus tasks
    // ------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low, then released a cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'h0);
        q = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        check(q, e);
    endtask
    // ------
    // expected replies
    // ------
    function automatic logic [15:0] stat_of(input logic [11:0] f, input logic [1:0] u);
        stat_of = {1'h0, u, 13'h0};
        for (int i = 0; i < 12; i++) if (f[i]) stat_of |= map_m[i];
    endfunction
    function automatic logic [6:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 7'h30 + 7'(n) : 7'h37 + 7'(n);
    endfunction
    task automatic push(input logic [6:0] c, input logic pb);
        exp_q.push_back({c, ^c, pb});
    endtask
    // fr 0 bare, 1 start/end plus check digits, 2 carriage returns
    task automatic build(input int fr, input logic [15:0] s, input logic pb);
        logic [6:0] body [8];
        logic [6:0] x;
        body = '{7'h33, 7'h31, 7'h30, 7'h20, hx(s[15:12]), hx(s[11:8]), hx(s[7:4]), hx(s[3:0])};
        x = 7'h0;
        exp_q.delete();
        if (fr == 1) push(7'h02, pb);
        if (fr == 2) push(7'h0D, pb);
        foreach (body[i]) push(body[i], pb);
        if (fr == 1) push(7'h03, pb);
        if (fr == 2) push(7'h0D, pb);
        foreach (exp_q[i]) x ^= exp_q[i].char;
        if (fr == 1) push(hx({1'h0, x[6:4]}), pb);
        if (fr == 1) push(hx(x[3:0]), pb);
    endtask
    task automatic cmp_reply();
        check(32'(i_host.rx_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) if (i < i_host.rx_q.size()) check(32'(i_host.rx_q[i]), 32'(exp_q[i]));
        i_host.rx_q.delete();
    endtask
    // commands only once the previous reply is over, except on purpose
    task automatic transact(input logic [15:0] id, input logic pb, input logic [1:0] enc);
        i_host.send(id, pb, enc);
        repeat (2) @(posedge clk_sys_in);
        while (busy_out !== 1'h0) @(posedge clk_sys_in);
    endtask
    // ------
    // main sequence and watchdog
    // ------
    initial begin
        logic [1:0] u;
        void'($urandom(61));
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        @(posedge clk_sys_in);
        foreach (map_m[i]) map_m[i] = 16'h1 << i;
        rd_chk(8'h00, 32'h6);
        rd_chk(8'h04, 32'h168);
        rd_chk(8'h08, 32'h310);
        rd_chk(8'h24, 32'h0);
        foreach (map_m[i]) rd_chk(8'h40 + 8'(4 * i), 32'(map_m[i]));
        // every response mode against every command encoding, random flags and unit
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 4; e++) begin
                u = 2'($urandom());
                wr(8'h00, {25'h0, u, 2'(m), 2'h3, 1'(e)});
                @(posedge clk_sys_in);
                check(32'(proto_v2_out), 32'(e & 1));
                flags_in <= 12'($urandom());
                i_host.slow = m[0];
                transact(16'h168, 1'(e >> 1), 2'(e));
                build((m == 1 || m == 2) ? m : (e == 3 ? 0 : e), stat_of(flags_in, u), 1'(e >> 1));
                cmp_reply();
            end
        end
        // events stay silent until unmasked; a written one clears them
        rd_chk(8'h10, 32'h5);
        check(32'(irq_out), 32'h0);
        wr(8'h14, 32'h1);
        repeat (2) @(posedge clk_sys_in);
        check(32'(irq_out), 32'h1);
        wr(8'h10, 32'h7);
        repeat (2) @(posedge clk_sys_in);
        check(32'(irq_out), 32'h0);
        // two flags share one bit; spare bits cannot be mapped
        map_m[3] = 16'h1;
        wr(8'h4C, 32'h1);
        wr(8'h50, 32'hF010);
        rd_chk(8'h50, 32'h10);
        wr(8'h00, 32'h4C);
        flags_in <= 12'h009;
        transact(16'h168, 1'h0, 2'h0);
        transact(16'h169, 1'h1, 2'h0);
        repeat (LAT + 10) @(posedge clk_sys_in);
        check(32'(i_host.rx_q.size()), 32'h0);
        transact(16'h168, 1'h1, 2'h0);
        build(1, stat_of(flags_in, 2'h2), 1'h1);
        cmp_reply();
        rd_chk(8'h0C, 32'h4001);
        // a second command while busy is dropped and flagged
        i_host.send(16'h168, 1'h1, 2'h0);
        repeat (3) @(posedge clk_sys_in);
        transact(16'h168, 1'h1, 2'h0);
        cmp_reply();
        rd_chk(8'h10, 32'h7);
        rd_chk(8'h18, 32'h0);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
